// >>> core/ssmc_core.sv
module ssmc_core
	import ssmc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire ssmc_wb_req_t wb_i,
	output ssmc_wb_rsp_t wb_o,
	// Link side
	input wire logic link_clk_i,
	input wire logic rxd_i,
	output logic txd_o,
	output logic rts_n_o,
	// Timer overflow pulse, same clock domain
	input wire logic timer_ovf_i
);

	typedef struct packed {
		logic [7:0] serial_mode_reg;
		logic [7:0] status_command_reg;
		logic [7:0] station_addr;
		logic [7:0] tx_len;
		logic [7:0] rx_len;
		logic [7:0] tx_ctrl;
		logic [7:0] rx_ctrl;
		logic [7:0] auto_ctrl;
		logic ack;
		logic [31:0] rdat;
		logic lclk_s1;
		logic lclk_s2;
		logic rxd_s1;
		logic rxd_s2;
		ssmc_tx_st_t tx_st;
		logic [7:0] tx_sh;
		logic [2:0] tx_bc;
		logic [7:0] tx_idx;
		logic [2:0] tx_ones;
		logic [15:0] tx_crc;
		logic tx_line;
		logic tx_auto;
		logic rx_act;
		logic [7:0] rx_sh;
		logic [2:0] rx_bc;
		logic [2:0] rx_ones;
		logic [15:0] rx_crc;
		logic [15:0] rx_crc_b;
		logic [7:0] rx_cnt;
		logic rx_prev;
		logic [2:0] nr;
		logic txd;
		logic rts_n;
	} ssmc_core_st_t;

	ssmc_core_st_t s, n;
	logic [7:0] buf_mem [0:BUF_BYTES-1];
	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;
	logic tx_tick, rx_tick;

	// Mode decode
	logic no_check_field, no_control_field, preframe_sync, loop_cfg, nrzi;
	logic [2:0] clock_mode_sel;
	logic mode_ok, auto_mode, non_addressed;
	// Work variables
	logic [7:0] bidx, rd, hdr, last, nidx, nbyte, rbyte, pos;
	logic tb, rb, stuffing;
	logic [15:0] crc_n;

	// ==========================================================
	// Bit clock
	ssmc_bitclk u_bitclk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clock_mode_sel_i(clock_mode_sel),
		.link_clk_i(s.lclk_s2),
		.timer_ovf_i(timer_ovf_i),
		.tx_tick_o(tx_tick),
		.rx_tick_o(rx_tick)
	);

	assign no_check_field = s.serial_mode_reg[MD_NO_CHECK];
	assign no_control_field = s.serial_mode_reg[MD_NO_CTRL];
	assign preframe_sync = s.serial_mode_reg[MD_PRESYNC];
	assign loop_cfg = s.serial_mode_reg[MD_LOOP];
	assign nrzi = s.serial_mode_reg[MD_NRZI];
	assign clock_mode_sel = s.serial_mode_reg[MD_CLK_LO +: 3];
	assign mode_ok = (clock_mode_sel != CM_UNDEF_A) && (clock_mode_sel != CM_UNDEF_B);
	assign auto_mode = !no_control_field && s.status_command_reg[ST_AM];
	assign non_addressed = no_control_field && !s.status_command_reg[ST_AM];

	always_comb begin
		n = s;
		mem_we = 1'b0;
		mem_wa = 8'h00;
		mem_wd = 8'h00;
		bidx = 8'h00;
		rd = 8'h00;
		nidx = 8'h00;
		nbyte = 8'h00;
		rbyte = 8'h00;
		pos = 8'h00;
		tb = 1'b0;
		rb = 1'b0;
		stuffing = 1'b0;
		crc_n = s.tx_crc;
		hdr = no_control_field ? 8'h01 : 8'h02;
		last = s.tx_auto ? 8'h01 : s.tx_len + 8'h01;
		// Link inputs: second flop only feeds logic
		n.lclk_s1 = link_clk_i;
		n.lclk_s2 = s.lclk_s1;
		n.rxd_s1 = rxd_i;
		n.rxd_s2 = s.rxd_s1;

		// ======================================================
		// Wishbone slave: ack one cycle after the request
		n.ack = 1'b0;
		if (wb_i.cyc && wb_i.stb && !s.ack) begin
			n.ack = 1'b1;
			bidx = wb_i.adr[9:2];
			if (wb_i.adr[11:10] == ADR_MEM_SEL) begin
				if (bidx < 8'(BUF_BYTES)) begin
					rd = buf_mem[bidx];
					if (wb_i.we && wb_i.sel[0]) begin
						mem_we = 1'b1;
						mem_wa = bidx;
						mem_wd = wb_i.dat[7:0];
					end
				end
			end else begin
				unique case (wb_i.adr)
					ADR_MODE: rd = s.serial_mode_reg;
					ADR_STATUS: rd = s.status_command_reg;
					ADR_STATION: rd = s.station_addr;
					ADR_TX_LEN: rd = s.tx_len;
					ADR_RX_LEN: rd = s.rx_len;
					ADR_TX_CTRL: rd = s.tx_ctrl;
					ADR_RX_CTRL: rd = s.rx_ctrl;
					default: rd = 8'h00;
				endcase
				if (wb_i.we && wb_i.sel[0]) begin
					unique case (wb_i.adr)
						ADR_MODE: n.serial_mode_reg = wb_i.dat[7:0];
						ADR_STATUS: n.status_command_reg = wb_i.dat[7:0];
						ADR_STATION: n.station_addr = wb_i.dat[7:0];
						ADR_TX_LEN: n.tx_len = (wb_i.dat[7:0] > BLK_BYTES) ? BLK_BYTES :
							wb_i.dat[7:0];
						ADR_TX_CTRL: n.tx_ctrl = wb_i.dat[7:0];
						default: n.ack = 1'b1;
					endcase
				end
			end
			n.rdat = {24'h000000, rd};
		end

		// ======================================================
		// Transmitter
		if (s.tx_st == TX_IDLE) begin
			if (s.status_command_reg[ST_TBF] && mode_ok && !s.rx_act) begin
				n.tx_st = preframe_sync ? TX_SYNC : TX_OPEN;
				n.tx_sh = preframe_sync ? (nrzi ? SYNC_NRZI : SYNC_NRZ) : FLAG;
				n.tx_bc = 3'h0;
				n.tx_idx = 8'h00;
				n.tx_ones = 3'h0;
				n.tx_crc = CRC_INIT;
				n.status_command_reg[ST_RTS] = 1'b1;
			end
		end else if (tx_tick) begin
			// A run of five ones ending the last check byte still needs its zero
			// before the closing flag starts
			stuffing = (s.tx_st == TX_BODY || s.tx_st == TX_FCS ||
				(s.tx_st == TX_CLOSE && s.tx_bc == 3'h0)) && s.tx_ones == 3'h5;
			if (stuffing) begin
				tb = 1'b0;
				n.tx_ones = 3'h0;
			end else begin
				tb = s.tx_sh[0];
				n.tx_sh = s.tx_sh >> 1;
				n.tx_bc = s.tx_bc + 3'h1;
				n.tx_ones = tb ? s.tx_ones + 3'h1 : 3'h0;
				if (s.tx_st == TX_BODY) begin
					crc_n = ssmc_crc_step(s.tx_crc, tb);
					n.tx_crc = crc_n;
				end
				if (s.tx_bc == 3'h7) begin
					nidx = (s.tx_idx == 8'h00 && no_control_field) ? 8'h02 : s.tx_idx + 8'h01;
					nbyte = (nidx == 8'h01) ? (s.tx_auto ? s.auto_ctrl : s.tx_ctrl) :
						buf_mem[TX_BASE + nidx - 8'h02];
					unique case (s.tx_st)
						TX_SYNC: begin
							if (s.tx_idx == 8'h01) begin
								n.tx_st = TX_OPEN;
								n.tx_sh = FLAG;
								n.tx_idx = 8'h00;
							end else begin
								n.tx_idx = 8'h01;
								n.tx_sh = nrzi ? SYNC_NRZI : SYNC_NRZ;
							end
						end
						TX_OPEN: begin
							n.tx_st = TX_BODY;
							n.tx_sh = s.station_addr;
							n.tx_idx = 8'h00;
							n.tx_ones = 3'h0;
						end
						TX_BODY: begin
							if (nidx <= last) begin
								n.tx_idx = nidx;
								n.tx_sh = nbyte;
							end else if (no_check_field) begin
								n.tx_st = TX_CLOSE;
								n.tx_sh = FLAG;
							end else begin
								n.tx_st = TX_FCS;
								n.tx_idx = 8'h00;
								n.tx_sh = ~crc_n[7:0];
							end
						end
						TX_FCS: begin
							if (s.tx_idx == 8'h00) begin
								n.tx_idx = 8'h01;
								n.tx_sh = ~s.tx_crc[15:8];
							end else begin
								n.tx_st = TX_CLOSE;
								n.tx_sh = FLAG;
							end
						end
						TX_CLOSE: begin
							n.tx_st = TX_IDLE;
							n.tx_auto = 1'b0;
							n.status_command_reg[ST_TBF] = 1'b0;
							n.status_command_reg[ST_RTS] = 1'b0;
							n.status_command_reg[ST_SI] = 1'b1;
						end
						default: n.tx_st = TX_IDLE;
					endcase
				end
			end
			n.tx_line = nrzi ? (tb ? s.tx_line : !s.tx_line) : tb;
		end
		// Loop station repeats the line while not sending
		n.txd = (loop_cfg && s.tx_st == TX_IDLE) ? s.rxd_s2 : s.tx_line;
		n.rts_n = loop_cfg ? 1'b1 : !s.status_command_reg[ST_RTS];

		// ======================================================
		// Receiver
		if (rx_tick) begin
			rb = nrzi ? (s.rxd_s2 == s.rx_prev) : s.rxd_s2;
			n.rx_prev = s.rxd_s2;
			if (rb) begin
				n.rx_ones = (s.rx_ones == 3'h7) ? 3'h7 : s.rx_ones + 3'h1;
				if (s.rx_ones >= 3'h6) begin
					n.rx_act = 1'b0;
				end
			end else begin
				n.rx_ones = 3'h0;
			end
			if (!rb && s.rx_ones == 3'h6) begin
				// Closing flag: the flag's first seven bits sit in the shifter
				if (s.rx_act && s.rx_bc == 3'h7 &&
					s.rx_cnt >= hdr + (no_check_field ? 8'h00 : 8'h02) &&
					(no_check_field || s.rx_crc_b == CRC_GOOD)) begin
					n.rx_len = s.rx_cnt - hdr - (no_check_field ? 8'h00 : 8'h02);
					n.status_command_reg[ST_RBE] = 1'b0;
					n.status_command_reg[ST_SI] = 1'b1;
					if (auto_mode) begin
						if (!s.rx_ctrl[0]) begin
							n.nr = s.nr + 3'h1;
						end
						if (s.rx_ctrl[CTRL_POLL] && s.tx_st == TX_IDLE) begin
							n.auto_ctrl = {(s.rx_ctrl[0] ? s.nr : s.nr + 3'h1), 5'h00} |
								(s.status_command_reg[ST_RBP] ? CTRL_RNR : CTRL_RR);
							n.tx_auto = 1'b1;
							n.status_command_reg[ST_TBF] = 1'b1;
						end
					end
				end
				n.rx_act = n.status_command_reg[ST_RBE];
				n.rx_bc = 3'h0;
				n.rx_cnt = 8'h00;
				n.rx_crc = CRC_INIT;
			end else if (!(!rb && s.rx_ones == 3'h5) && s.rx_act) begin
				// Data bit; a zero after five ones is dropped
				n.rx_sh = {rb, s.rx_sh[7:1]};
				n.rx_crc = ssmc_crc_step(s.rx_crc, rb);
				n.rx_bc = s.rx_bc + 3'h1;
				if (s.rx_bc == 3'h7) begin
					rbyte = {rb, s.rx_sh[7:1]};
					n.rx_crc_b = n.rx_crc;
					n.rx_cnt = s.rx_cnt + 8'h01;
					pos = s.rx_cnt - hdr;
					if (s.rx_cnt == 8'h00) begin
						// Multipoint address filter
						n.rx_act = non_addressed || rbyte == s.station_addr || rbyte == BCAST;
					end else if (s.rx_cnt == 8'h01 && !no_control_field) begin
						n.rx_ctrl = rbyte;
					end else if (pos < BLK_BYTES) begin
						if (!s.status_command_reg[ST_RBP]) begin
							mem_we = 1'b1;
							mem_wa = RX_BASE + pos;
							mem_wd = rbyte;
						end
					end else begin
						n.status_command_reg[ST_BOV] = 1'b1;
					end
				end
			end
		end
		if (!mode_ok) begin
			n.rx_act = 1'b0;
		end
		// FLEXIBLE mode: nothing above answers on its own
	end

	// ==========================================================
	// State and buffer memory; a receiver write wins over a bus write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.serial_mode_reg <= MODE_RST;
			s.status_command_reg <= STATUS_RST;
			s.tx_st <= TX_IDLE;
			s.txd <= 1'b1;
			s.rts_n <= 1'b1;
			s.tx_line <= 1'b1;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			buf_mem[mem_wa] <= mem_wd;
		end
	end

	assign wb_o = '{ack: s.ack, dat: s.rdat};
	assign txd_o = s.txd;
	assign rts_n_o = s.rts_n;

endmodule // ssmc_core

// >>> core/ssmc_pkg.sv
package ssmc_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned FAST_BPS = 375_000;
	localparam int unsigned SLOW_BPS = 187_500;
	localparam logic [10:0] FAST_DIV = 11'(CLK_HZ / FAST_BPS);
	localparam logic [10:0] SLOW_DIV = 11'(CLK_HZ / SLOW_BPS);
	localparam logic [10:0] REF16_DIV = 11'h010;
	localparam logic [10:0] REF32_DIV = 11'h020;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] ADR_MODE = 12'h000;
	localparam logic [11:0] ADR_STATUS = 12'h004;
	localparam logic [11:0] ADR_STATION = 12'h008;
	localparam logic [11:0] ADR_TX_LEN = 12'h00c;
	localparam logic [11:0] ADR_RX_LEN = 12'h010;
	localparam logic [11:0] ADR_TX_CTRL = 12'h014;
	localparam logic [11:0] ADR_RX_CTRL = 12'h018;
	localparam logic [1:0] ADR_MEM_SEL = 2'h1;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// Mode register fields
	localparam int MD_NO_CHECK = 0;
	localparam int MD_NO_CTRL = 1;
	localparam int MD_PRESYNC = 2;
	localparam int MD_LOOP = 3;
	localparam int MD_NRZI = 4;
	localparam int MD_CLK_LO = 5;
	// Status/command fields
	localparam int ST_RBP = 0;
	localparam int ST_AM = 1;
	localparam int ST_BOV = 3;
	localparam int ST_SI = 4;
	localparam int ST_RTS = 5;
	localparam int ST_RBE = 6;
	localparam int ST_TBF = 7;

	// Clock mode codes
	localparam logic [2:0] CM_EXT = 3'h0;
	localparam logic [2:0] CM_UNDEF_A = 3'h1;
	localparam logic [2:0] CM_TIMER = 3'h2;
	localparam logic [2:0] CM_UNDEF_B = 3'h3;
	localparam logic [2:0] CM_REF16 = 3'h4;
	localparam logic [2:0] CM_REF32 = 3'h5;
	localparam logic [2:0] CM_FAST = 3'h6;
	localparam logic [2:0] CM_SLOW = 3'h7;

	// ==========================================================
	// Framing
	localparam logic [7:0] FLAG = 8'h7e;
	localparam logic [7:0] SYNC_NRZI = 8'h00;
	localparam logic [7:0] SYNC_NRZ = 8'h55;
	localparam logic [7:0] BCAST = 8'hff;
	localparam logic [7:0] CTRL_RR = 8'h11;
	localparam logic [7:0] CTRL_RNR = 8'h15;
	localparam int CTRL_POLL = 4;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;
	localparam int BUF_BYTES = 192;
	localparam logic [7:0] TX_BASE = 8'h00;
	localparam logic [7:0] RX_BASE = 8'h60;
	localparam logic [7:0] BLK_BYTES = 8'h60;

	// ==========================================================
	// Types
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [11:0] adr;
		logic [31:0] dat;
	} ssmc_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ssmc_wb_rsp_t;

	typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_OPEN, TX_BODY, TX_FCS, TX_CLOSE} ssmc_tx_st_t;

	function automatic logic [15:0] ssmc_crc_step(input logic [15:0] c, input logic b);
		ssmc_crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
	endfunction

endpackage

// >>> core/ssmc_bitclk.sv
module ssmc_bitclk
	import ssmc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Mode and sources
	input wire logic [2:0] clock_mode_sel_i,
	input wire logic link_clk_i,
	input wire logic timer_ovf_i,
	// Bit strobes
	output logic tx_tick_o,
	output logic rx_tick_o
);

	typedef struct packed {
		logic ref_prev;
		logic phase;
		logic [10:0] cnt;
		logic tx_tick;
		logic rx_tick;
	} ssmc_bitclk_st_t;

	ssmc_bitclk_st_t s, n;
	logic rise, fall;
	logic [10:0] div;

	// ==========================================================
	// Tick generation; no phase tracking of the incoming data, so
	// recovered-clock modes rely on the reference being clean
	always_comb begin
		n = s;
		n.tx_tick = 1'b0;
		n.rx_tick = 1'b0;
		n.ref_prev = link_clk_i;
		rise = link_clk_i && !s.ref_prev;
		fall = !link_clk_i && s.ref_prev;
		div = (clock_mode_sel_i == CM_REF16) ? REF16_DIV :
			(clock_mode_sel_i == CM_REF32) ? REF32_DIV :
			(clock_mode_sel_i == CM_FAST) ? FAST_DIV : SLOW_DIV;
		unique case (clock_mode_sel_i)
			CM_EXT: begin
				n.rx_tick = rise;
				n.tx_tick = fall;
			end
			CM_TIMER: begin
				if (timer_ovf_i) begin
					n.phase = !s.phase;
					n.tx_tick = !s.phase;
					n.rx_tick = s.phase;
				end
			end
			CM_REF16, CM_REF32: begin
				if (rise) begin
					n.cnt = (s.cnt >= div - 11'h001) ? 11'h000 : s.cnt + 11'h001;
					n.tx_tick = (s.cnt == 11'h000);
					n.rx_tick = (s.cnt == (div >> 1));
				end
			end
			CM_FAST, CM_SLOW: begin
				n.cnt = (s.cnt >= div - 11'h001) ? 11'h000 : s.cnt + 11'h001;
				n.tx_tick = (s.cnt == 11'h000);
				n.rx_tick = (s.cnt == (div >> 1));
			end
			default: begin
				n.cnt = 11'h000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tx_tick_o = s.tx_tick;
	assign rx_tick_o = s.rx_tick;

endmodule // ssmc_bitclk

// >>> bench/ssmc_core_chk.sv
module ssmc_core_chk
	import ssmc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire ssmc_wb_req_t wb_i,
	input wire ssmc_wb_rsp_t wb_o,
	// Link side
	input wire logic link_clk_i,
	input wire logic rxd_i,
	input wire logic txd_o,
	input wire logic rts_n_o,
	input wire logic timer_ovf_i
);
	// ==========
	// Mode shadow, taken when the write is acknowledged
	logic [7:0] mode;
	logic cm_bad;
	logic rd_ack;
	assign rd_ack = wb_o.ack && !wb_i.we;
	assign cm_bad = (mode[7:5] == CM_UNDEF_A || mode[7:5] == CM_UNDEF_B) && !mode[MD_LOOP];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= MODE_RST;
		end else if (wb_o.ack && wb_i.we && wb_i.sel[0] && wb_i.adr[11:2] == ADR_MODE[11:2]) begin
			mode <= wb_i.dat[7:0];
		end
	end
	// ==========
	// Sequences
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_i.cyc && wb_i.stb && !wb_o.ack;
	endsequence
	sequence s_send;
		s_take ##0 (wb_i.we && wb_i.sel[0] && wb_i.dat[7] && wb_i.adr[11:2] == ADR_STATUS[11:2]);
	endsequence
	sequence s_echo;
		(mode[MD_LOOP] && $stable(rxd_i)) [*6];
	endsequence
	// ==========
	// Assertions
	AST_ACK_NEXT: assert property (s_take |=> wb_o.ack)
		else $error("ack missing one cycle after request");
	AST_ACK_PULSE: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack longer than one cycle");
	AST_RD_BYTE: assert property (wb_o.ack |-> wb_o.dat[31:8] == 24'h0)
		else $error("read data above low byte not zero");
	AST_MODE_RD: assert property (rd_ack && wb_i.adr[11:2] == ADR_MODE[11:2] |->
		wb_o.dat[7:0] == mode) else $error("mode read differs from last write");
	AST_UNMAPPED: assert property (rd_ack && wb_i.adr[11:10] == 2'h0 &&
		wb_i.adr[9:2] > 8'h06 |-> wb_o.dat == 32'h0) else $error("unmapped read not zero");
	AST_RST_IDLE: assert property ($fell(rst_i) |-> txd_o && rts_n_o && !wb_o.ack)
		else $error("outputs not idle after reset");
	AST_LOOP_RTS: assert property (mode[MD_LOOP] && $past(mode[MD_LOOP]) |-> rts_n_o)
		else $error("send request pin driven in loop");
	AST_RTS_ON_SEND: assert property (s_send ##0 (!mode[MD_LOOP] && !cm_bad) |->
		##[1:4] !rts_n_o) else $error("send request pin did not follow");
	AST_UNDEF_QUIET: assert property (cm_bad && $past(cm_bad) |-> $stable(txd_o))
		else $error("line moved with undefined clock code");
	AST_LOOP_ECHO: assert property (s_echo |-> txd_o == rxd_i)
		else $error("loop line not repeated");
endmodule // ssmc_core_chk

bind ssmc_core ssmc_core_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
	.link_clk_i(link_clk_i), .rxd_i(rxd_i), .txd_o(txd_o), .rts_n_o(rts_n_o),
	.timer_ovf_i(timer_ovf_i));

// >>> bench/ssmc_remote_stn.sv
module ssmc_remote_stn (
	// Bench control
	input wire logic run_i,
	input wire logic line_i,
	// Link
	input wire logic txd_i,
	output logic link_clk_o,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// Bit clock stands low between frames
	logic seen [$];
	assign rxd_o = line_i;
	initial begin
		link_clk_o = 1'b0;
		#3;
		forever begin
			#40;
			link_clk_o = run_i ? !link_clk_o : 1'b0;
		end
	end
	always @(posedge link_clk_o) begin
		seen.push_back(txd_i);
	end
endmodule // ssmc_remote_stn

// >>> bench/test_sdlc_serial_mode_config.sv
module test_sdlc_serial_mode_config
	import ssmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// Signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic line = 1'b1;
	logic timer_ovf = 1'b0;
	logic link_clk;
	logic rxd;
	logic txd;
	logic rts_n;
	ssmc_wb_req_t wb_req = '0;
	ssmc_wb_rsp_t wb_rsp;
	logic [31:0] seed = 32'h4bc8;
	logic [7:0] rd;
	logic [7:0] m;
	logic ex [$];
	int ones;
	int tcnt = 0;
	int n_mismatch = 0;
	int tests_run = 0;
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	ssmc_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
		.link_clk_i(link_clk), .rxd_i(rxd), .txd_o(txd), .rts_n_o(rts_n), .timer_ovf_i(timer_ovf));
	ssmc_remote_stn stn (.run_i(run), .line_i(line), .txd_i(txd), .link_clk_o(link_clk),
		.rxd_o(rxd));
	// Timer overflows every 8 cycles
	always @(posedge clk_i) begin
		tcnt <= (tcnt == 7) ? 0 : tcnt + 1;
		timer_ovf <= (tcnt == 7);
	end
	// ==========
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic timeout();
		n_mismatch++;
		print_verdict();
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d, input logic s);
		int n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: {3'h0, s}, adr: adr, dat: {24'h0, d}};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			timeout();
		end
		rd = wb_rsp.dat[7:0];
		wb_req <= '0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [11:0] adr, input logic [7:0] d);
		wb(1'b1, adr, d, 1'b1);
	endtask
	task automatic rdr(input logic [11:0] adr);
		wb(1'b0, adr, 8'h00, 1'b1);
	endtask
	task automatic do_reset();
		run <= 1'b0;
		line <= 1'b1;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic wt(input logic lvl);
		int n = 0;
		while (rts_n !== lvl && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 9000) begin
			timeout();
		end
	endtask
	task automatic put(input logic [7:0] v, input logic stf);
		for (int k = 0; k < 8; k++) begin
			ex.push_back(v[k]);
			ones = (stf && v[k]) ? ones + 1 : 0;
			if (ones == 5) begin
				ex.push_back(1'b0);
				ones = 0;
			end
		end
	endtask
	function automatic int per(input logic [2:0] cm);
		case (cm)
			CM_EXT: return 20;
			CM_TIMER: return 16;
			CM_REF16: return 16 * 20;
			CM_REF32: return 32 * 20;
			CM_FAST: return int'(FAST_DIV);
			CM_SLOW: return int'(SLOW_DIV);
			default: return -1;
		endcase
	endfunction
	// Gap between the first two line changes of a 55h sync is one bit time
	task automatic rate(input logic [2:0] cm);
		int n = 0;
		int t0 = -1;
		logic pv;
		do_reset();
		run <= 1'b1;
		wr(ADR_MODE, {cm, 5'h04});
		wr(ADR_STATUS, 8'h80);
		pv = txd;
		while (n < 6000) begin
			@(posedge clk_i);
			n++;
			if (txd !== pv && t0 >= 0) break;
			if (txd !== pv) t0 = n;
			pv = txd;
		end
		check((t0 < 0) ? -1 : n - t0, per(cm));
	endtask
	task automatic frame(input logic [7:0] md, input int len);
		logic [7:0] by [$];
		logic [15:0] c;
		logic lv;
		int k;
		do_reset();
		wr(ADR_MODE, md);
		by.push_back(8'(xs()));
		wr(ADR_STATION, by[0]);
		by.push_back(8'(xs()));
		wr(ADR_TX_CTRL, by[1]);
		if (md[MD_NO_CTRL]) by.pop_back();
		wr(ADR_TX_LEN, 8'(len));
		for (int i = 0; i < len; i++) begin
			by.push_back(8'(xs()));
			wr(12'h400 + 12'(4 * i), by[$]);
		end
		c = CRC_INIT;
		foreach (by[i]) for (int b = 0; b < 8; b++) c = (c[0] ^ by[i][b]) ? (c >> 1) ^ CRC_POLY : c >> 1;
		if (!md[MD_NO_CHECK]) by.push_back(~c[7:0]);
		if (!md[MD_NO_CHECK]) by.push_back(~c[15:8]);
		ex.delete();
		if (md[MD_PRESYNC]) repeat (2) put(md[MD_NRZI] ? 8'h00 : 8'h55, 1'b0);
		put(8'h7e, 1'b0);
		foreach (by[i]) put(by[i], 1'b1);
		put(8'h7e, 1'b0);
		stn.seen.delete();
		run <= 1'b1;
		wr(ADR_STATUS, 8'h80);
		wt(1'b0);
		wt(1'b1);
		repeat (40) @(posedge clk_i);
		run <= 1'b0;
		k = 0;
		while (k < stn.seen.size() && stn.seen[k] === 1'b1) k++;
		lv = 1'b1;
		foreach (ex[i]) begin
			lv = lv ^ !ex[i];
			check(stn.seen[k + i], md[MD_NRZI] ? lv : ex[i]);
		end
		rdr(ADR_STATUS);
		check(rd, 8'h10);
	endtask
	// ==========
	// Main sequence
	initial begin
		do_reset();
		rdr(ADR_MODE);
		check(rd, MODE_RST);
		m = 8'(xs());
		wr(ADR_MODE, m);
		wb(1'b1, ADR_MODE, ~m, 1'b0);
		rdr(ADR_MODE);
		check(rd, m);
		wr(12'h020, 8'hff);
		rdr(12'h020);
		check(rd, 8'h00);
		rdr(ADR_STATUS);
		check(rd, STATUS_RST);
		for (int c = 0; c < 8; c++) rate(3'(c));
		frame(8'h14, 3);
		frame(8'h03, 2);
		do_reset();
		wr(ADR_MODE, 8'h08);
		line <= 1'b0;
		repeat (8) @(posedge clk_i);
		check(txd, 1'b0);
		line <= 1'b1;
		repeat (8) @(posedge clk_i);
		check(txd, 1'b1);
		print_verdict();
	end
endmodule // test_sdlc_serial_mode_config
